// file: rtl/uart_cfg_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef UART_CFG_MAP_SVH
`define UART_CFG_MAP_SVH
// Byte offsets inside one channel window
`define UCFG_OFF_DATA 5'h00
`define UCFG_OFF_LINE 5'h04
`define UCFG_OFF_FIFO 5'h08
`define UCFG_OFF_MODEM 5'h0c
`define UCFG_OFF_ENH 5'h10
`define UCFG_OFF_DIV 5'h14
`define UCFG_OFF_STAT 5'h18
// Field positions
`define UCFG_LINE_DLAB 7
`define UCFG_FIFO_DEEP 5
`define UCFG_MODEM_IR 6
`define UCFG_ENH_EN 0
`define UCFG_STAT_RXV 0
`define UCFG_STAT_TXB 1
`define UCFG_STAT_PIN 2
`define UCFG_STAT_DEEP 3
// Reset values
`define UCFG_RST_BYTE 8'h00
`define UCFG_RST_DIV 16'h0001
// FIFO depths reported to software
`define UCFG_DEPTH_SHALLOW 8'h10
`define UCFG_DEPTH_DEEP 8'h80
// Oversampling: 16 ticks per bit, mid-bit sample, 3-tick pulse
`define UCFG_PHASE_LAST 4'hf
`define UCFG_PHASE_MID 4'h7
`define UCFG_IR_PULSE 4'h3
`define UCFG_FRAME_BITS 4'ha
`define UCFG_DATA_LAST 3'h7
`endif

// file: rtl/uart_cfg_pkg.sv
// Types shared by the channel configuration block
package uart_cfg_pkg;
  // Receiver states, Gray coded along the frame
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_e;
  // Bus data word
  typedef logic [31:0] word_t;
endpackage : uart_cfg_pkg

// file: rtl/irda_tx_enc.sv
// Transmit pin driver: plain serial or infrared pulse encoding
`timescale 1ns/100ps
`include "uart_cfg_map.svh"
module irda_tx_enc (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic nrz_i,
  input wire logic ir_en_i,
  input wire logic [3:0] phase_i,
  output logic pin_o
);
  logic pulse; // Short high pulse for a zero bit
  logic pin_d;
  logic pin_q;

  // Zero bits become a pulse in the first ticks of the bit
  assign pulse = ~nrz_i & (phase_i < `UCFG_IR_PULSE);
  // Infrared only when selected, else plain level
  assign pin_d = ir_en_i ? pulse : nrz_i;

  // Pin register, idle high in serial mode
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign pin_o = pin_q;
endmodule : irda_tx_enc

// file: rtl/irda_rx_dec.sv
// Receive pin decoder: infrared pulses back to serial levels
`timescale 1ns/100ps
`include "uart_cfg_map.svh"
module irda_rx_dec (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic ir_en_i,
  input wire logic rx_i,
  output logic nrz_o
);
  logic [3:0] hold_q; // Ticks left of a decoded zero bit
  logic [3:0] hold_d;
  logic nrz_d;
  logic nrz_q;
  logic holding;

  assign holding = (hold_q != 4'h0);
  // A pulse restarts one bit time of low output
  assign hold_d = (ir_en_i & rx_i) ? `UCFG_PHASE_LAST :
                  (tick_i & holding) ? hold_q - 4'h1 : hold_q;
  // Decoded level in infrared mode, raw level otherwise
  assign nrz_d = ir_en_i ? ~(rx_i | holding) : rx_i;

  // Hold counter and output level
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hold_q <= 4'h0;
      nrz_q <= 1'b1;
    end else begin
      hold_q <= hold_d;
      nrz_q <= nrz_d;
    end
  end

  assign nrz_o = nrz_q;
endmodule : irda_rx_dec

// file: rtl/uart_fifo_depth_irda_pinsel.sv
// Per-channel depth selection, infrared switching and APB registers
//
// Function
// - Select pin low gives 16-entry FIFOs
// - Select pin high gives 128-entry FIFOs
// - Deep bit written with divisor latch sets 128
// - Enhanced mode forces 128-entry FIFOs
// - Software reads present select pin level
// - Infrared mode encodes the transmit pin
// - Infrared mode decodes the receive pin
`timescale 1ns/100ps
`include "uart_cfg_map.svh"
module uart_fifo_depth_irda_pinsel #(
  parameter int NUM_CH = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire uart_cfg_pkg::word_t pwdata_i,
  output uart_cfg_pkg::word_t prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic fifo_depth_select_pin_i,
  input wire logic [NUM_CH-1:0] serial_rx_pin_i,
  output logic [NUM_CH-1:0] serial_tx_pin_o,
  output logic [NUM_CH-1:0] fifo_deep_o
);
  import uart_cfg_pkg::*;

  // Channel count must fit the two channel-select address bits
  if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 4");
  end

  // Depth value shown in the status word
  function automatic logic [7:0] depth_of(input logic deep);
    depth_of = deep ? `UCFG_DEPTH_DEEP : `UCFG_DEPTH_SHALLOW;
  endfunction : depth_of

  // Offset known to the channel window
  function automatic logic off_known(input logic [4:0] off);
    off_known = (off == `UCFG_OFF_DATA) || (off == `UCFG_OFF_LINE) ||
                (off == `UCFG_OFF_FIFO) || (off == `UCFG_OFF_MODEM) ||
                (off == `UCFG_OFF_ENH) || (off == `UCFG_OFF_DIV) ||
                (off == `UCFG_OFF_STAT);
  endfunction : off_known

  // Bus decode
  logic [1:0] ch_idx; // Channel window
  logic [4:0] off; // Offset in window
  logic mapped; // Address hits a register
  logic acc_wait; // Access phase, answer not yet given
  logic acc_done; // Completing edge of an access
  logic wr_en; // Write takes effect now
  logic rd_done; // Read completes now
  word_t rd_word; // Read data for current address
  word_t ch_rd [4]; // Read word of each window
  logic ready_q;
  word_t rdata_q;
  logic slverr_q;

  assign ch_idx = paddr_i[6:5];
  assign off = paddr_i[4:0];
  assign mapped = ~paddr_i[7] & (32'(ch_idx) < NUM_CH) & off_known(off);
  assign acc_wait = psel_i & penable_i & ~ready_q;
  assign acc_done = psel_i & penable_i & ready_q;
  assign wr_en = acc_done & pwrite_i & mapped;
  assign rd_done = acc_done & ~pwrite_i & mapped;
  assign rd_word = mapped ? ch_rd[ch_idx] : '0;

  // One wait state, then answer with data or error
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
      rdata_q <= '0;
      slverr_q <= 1'b0;
    end else begin
      ready_q <= acc_wait;
      // Data and error stand only in the ready cycle
      rdata_q <= '0;
      slverr_q <= 1'b0;
      if (acc_wait) begin
        rdata_q <= pwrite_i ? '0 : rd_word;
        slverr_q <= ~mapped;
      end
    end
  end

  assign pready_o = ready_q;
  assign prdata_o = rdata_q;
  assign pslverr_o = slverr_q;

  // Select pin synchroniser; stage one feeds stage two only
  logic pin_s1_q;
  logic pin_s2_q;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= fifo_depth_select_pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Per-channel state
  logic [7:0] line_control_reg_q [NUM_CH]; // Line control
  logic [7:0] modem_control_reg_q [NUM_CH]; // Modem control
  logic fifo_control_deep_q [NUM_CH]; // Deep bit of FIFO control
  logic enh_q [NUM_CH]; // Enhanced mode
  logic [15:0] div_q [NUM_CH]; // Tick divisor
  logic [15:0] div_cnt_q [NUM_CH]; // Tick counter
  logic deep_q [NUM_CH]; // Resulting deep FIFO flag
  logic [9:0] tx_sh_q [NUM_CH]; // Transmit frame shifter
  logic [3:0] tx_left_q [NUM_CH]; // Bits left to send
  logic [3:0] tx_ph_q [NUM_CH]; // Tick within bit
  rx_state_e rx_st_q [NUM_CH]; // Receiver state
  logic [3:0] rx_ph_q [NUM_CH]; // Receiver tick within bit
  logic [2:0] rx_cnt_q [NUM_CH]; // Data bit index
  logic [7:0] rx_sh_q [NUM_CH]; // Receive shifter
  logic [7:0] rx_data_q [NUM_CH]; // Last received byte
  logic rx_valid_q [NUM_CH]; // Unread byte waiting
  logic rx_s1_q [NUM_CH]; // Receive pin stage one
  logic rx_s2_q [NUM_CH]; // Receive pin stage two

  for (genvar i = 0; i < 4; i++) begin : g_ch
    if (i < NUM_CH) begin : g_on
      logic wr_ch; // Write to this window
      logic rd_ch; // Read completes in this window
      logic tick; // 16x bit-rate tick
      logic [15:0] div_eff; // Divisor, zero taken as one
      logic ir_en; // Infrared selected
      logic tx_busy; // Frame in progress
      logic tx_start; // Accepted transmit write
      logic tx_nrz; // Plain serial transmit level
      logic rx_nrz; // Plain serial receive level
      logic rx_set; // Byte received
      logic rx_clr; // Byte read by software

      assign wr_ch = wr_en & (ch_idx == 2'(i));
      assign rd_ch = rd_done & (ch_idx == 2'(i));
      assign div_eff = (div_q[i] == 16'h0) ? 16'h1 : div_q[i];
      assign tick = (div_cnt_q[i] == 16'h0);
      assign ir_en = enh_q[i] & modem_control_reg_q[i][`UCFG_MODEM_IR];
      assign tx_busy = (tx_left_q[i] != 4'h0);
      assign tx_start = wr_ch & (off == `UCFG_OFF_DATA) & ~tx_busy;
      assign tx_nrz = tx_busy ? tx_sh_q[i][0] : 1'b1;
      assign rx_clr = rd_ch & (off == `UCFG_OFF_DATA);

      // Read words of this window
      assign ch_rd[i] =
        (off == `UCFG_OFF_DATA) ? {24'h0, rx_data_q[i]} :
        (off == `UCFG_OFF_LINE) ? {24'h0, line_control_reg_q[i]} :
        (off == `UCFG_OFF_FIFO) ?
          {26'h0, fifo_control_deep_q[i], 5'h0} :
        (off == `UCFG_OFF_MODEM) ? {24'h0, modem_control_reg_q[i]} :
        (off == `UCFG_OFF_ENH) ? {31'h0, enh_q[i]} :
        (off == `UCFG_OFF_DIV) ? {16'h0, div_q[i]} :
        {16'h0, depth_of(deep_q[i]), 4'h0, deep_q[i], pin_s2_q,
         tx_busy, rx_valid_q[i]};

      // Control registers written by software
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          line_control_reg_q[i] <= `UCFG_RST_BYTE;
          modem_control_reg_q[i] <= `UCFG_RST_BYTE;
          fifo_control_deep_q[i] <= 1'b0;
          enh_q[i] <= 1'b0;
          div_q[i] <= `UCFG_RST_DIV;
        end else if (wr_ch) begin
          if (off == `UCFG_OFF_LINE) begin
            line_control_reg_q[i] <= pwdata_i[7:0];
          end
          if (off == `UCFG_OFF_MODEM) begin
            modem_control_reg_q[i] <= pwdata_i[7:0];
          end
          // Deep bit counts only with divisor latch bit set
          if ((off == `UCFG_OFF_FIFO) &&
              line_control_reg_q[i][`UCFG_LINE_DLAB]) begin
            fifo_control_deep_q[i] <= pwdata_i[`UCFG_FIFO_DEEP];
          end
          if (off == `UCFG_OFF_ENH) begin
            enh_q[i] <= pwdata_i[`UCFG_ENH_EN];
          end
          if (off == `UCFG_OFF_DIV) begin
            div_q[i] <= pwdata_i[15:0];
          end
        end
      end

      // Depth: pin level, deep bit or enhanced mode
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          deep_q[i] <= 1'b0;
        end else begin
          deep_q[i] <= pin_s2_q |
                       fifo_control_deep_q[i] |
                       enh_q[i];
        end
      end

      // Tick divider
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          div_cnt_q[i] <= 16'h0;
        end else begin
          div_cnt_q[i] <= tick ? div_eff - 16'h1 : div_cnt_q[i] - 16'h1;
        end
      end

      // Transmitter: start, eight data bits LSB first, stop
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          tx_sh_q[i] <= 10'h3ff;
          tx_left_q[i] <= 4'h0;
          tx_ph_q[i] <= 4'h0;
        end else if (tx_start) begin
          tx_sh_q[i] <= {1'b1, pwdata_i[7:0], 1'b0};
          tx_left_q[i] <= `UCFG_FRAME_BITS;
          tx_ph_q[i] <= 4'h0;
        end else if (tick & tx_busy) begin
          tx_ph_q[i] <= tx_ph_q[i] + 4'h1;
          if (tx_ph_q[i] == `UCFG_PHASE_LAST) begin
            tx_sh_q[i] <= {1'b1, tx_sh_q[i][9:1]};
            tx_left_q[i] <= tx_left_q[i] - 4'h1;
          end
        end
      end

      // Transmit pin, plain or infrared
      irda_tx_enc u_enc (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .nrz_i(tx_nrz),
        .ir_en_i(ir_en),
        .phase_i(tx_ph_q[i]),
        .pin_o(serial_tx_pin_o[i])
      );

      // Receive pin synchroniser
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          rx_s1_q[i] <= 1'b1;
          rx_s2_q[i] <= 1'b1;
        end else begin
          rx_s1_q[i] <= serial_rx_pin_i[i];
          rx_s2_q[i] <= rx_s1_q[i];
        end
      end

      // Receive pin, plain or infrared
      irda_rx_dec u_dec (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .ir_en_i(ir_en),
        .rx_i(rx_s2_q[i]),
        .nrz_o(rx_nrz)
      );

      assign rx_set = tick & (rx_st_q[i] == RX_STOP) &
                      (rx_ph_q[i] == `UCFG_PHASE_LAST) & rx_nrz;

      // Receiver: mid-bit sampling of a plain serial frame
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          rx_st_q[i] <= RX_IDLE;
          rx_ph_q[i] <= 4'h0;
          rx_cnt_q[i] <= 3'h0;
          rx_sh_q[i] <= 8'h0;
        end else if (tick) begin
          rx_ph_q[i] <= rx_ph_q[i] + 4'h1;
          case (rx_st_q[i])
            RX_IDLE: begin
              rx_ph_q[i] <= 4'h0;
              // Falling edge opens a frame
              if (!rx_nrz) begin
                rx_st_q[i] <= RX_START;
              end
            end
            RX_START: begin
              if (rx_ph_q[i] == `UCFG_PHASE_MID) begin
                // Glitch shorter than half a bit is dropped
                rx_st_q[i] <= rx_nrz ? RX_IDLE : RX_DATA;
                rx_ph_q[i] <= 4'h0;
                rx_cnt_q[i] <= 3'h0;
              end
            end
            RX_DATA: begin
              if (rx_ph_q[i] == `UCFG_PHASE_LAST) begin
                rx_sh_q[i] <= {rx_nrz, rx_sh_q[i][7:1]};
                rx_cnt_q[i] <= rx_cnt_q[i] + 3'h1;
                if (rx_cnt_q[i] == `UCFG_DATA_LAST) begin
                  rx_st_q[i] <= RX_STOP;
                end
              end
            end
            RX_STOP: begin
              // Bad stop bit discards the byte
              if (rx_ph_q[i] == `UCFG_PHASE_LAST) begin
                rx_st_q[i] <= RX_IDLE;
              end
            end
            default: begin
              rx_st_q[i] <= RX_IDLE;
            end
          endcase
        end
      end

      // Received byte and flag; a new byte beats a read clear
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          rx_data_q[i] <= 8'h0;
          rx_valid_q[i] <= 1'b0;
        end else if (rx_set) begin
          rx_data_q[i] <= rx_sh_q[i];
          rx_valid_q[i] <= 1'b1;
        end else if (rx_clr) begin
          rx_valid_q[i] <= 1'b0;
        end
      end

      assign fifo_deep_o[i] = deep_q[i];
    end else begin : g_off
      // Absent window reads zero
      assign ch_rd[i] = '0;
    end
  end
endmodule : uart_fifo_depth_irda_pinsel

// file: test/ucfg_checker.sv
// Bus and pin timing checks for the channel configuration block
`timescale 1ns/100ps
module ucfg_checker #(
  parameter int NUM_CH = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire uart_cfg_pkg::word_t pwdata_i,
  input wire uart_cfg_pkg::word_t prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic fifo_depth_select_pin_i,
  input wire logic [NUM_CH-1:0] serial_rx_pin_i,
  input wire logic [NUM_CH-1:0] serial_tx_pin_o,
  input wire logic [NUM_CH-1:0] fifo_deep_o
);
  import uart_cfg_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Exactly one wait state in the access phase
  a_ready_one_wait: assert property (psel_i && penable_i && !pready_o
    |=> pready_o) else $error("ready late");
  // Ready is a single-cycle pulse
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  // No answer outside an access
  a_ready_idle: assert property (!(psel_i && penable_i) |=> !pready_o)
    else $error("ready without access");
  // Error only comes with ready
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  // Refused accesses read zero
  a_err_data_zero: assert property (pslverr_o |-> prdata_o == '0)
    else $error("refused read not zero");
  // Upper address half is refused
  a_err_high_addr: assert property (pready_o && paddr_i[7] |-> pslverr_o)
    else $error("high address accepted");
  // Select pin high gives deep FIFOs everywhere
  a_deep_pin_high: assert property (fifo_depth_select_pin_i[*5]
    |-> &fifo_deep_o) else $error("pin high not deep");
  // Any level on the last channel's transmit pin lasts at least one pulse width
  a_tx_rise_wide: assert property ($rose(serial_tx_pin_o[NUM_CH-1])
    |=> serial_tx_pin_o[NUM_CH-1][*2]) else $error("short high");
  a_tx_fall_wide: assert property ($fell(serial_tx_pin_o[NUM_CH-1])
    |=> !serial_tx_pin_o[NUM_CH-1][*2]) else $error("short low");
endmodule : ucfg_checker
bind uart_fifo_depth_irda_pinsel ucfg_checker #(.NUM_CH(NUM_CH))
  ucfg_checker_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o),
  .fifo_depth_select_pin_i(fifo_depth_select_pin_i),
  .serial_rx_pin_i(serial_rx_pin_i), .serial_tx_pin_o(serial_tx_pin_o),
  .fifo_deep_o(fifo_deep_o));

// file: test/serial_line_model.sv
// Far-side serial or infrared transceiver model
`timescale 1ns/100ps
module serial_line_model #(
  parameter int NUM_CH = 2,
  parameter int BIT_CYC = 16
) (
  input wire logic core_clk_i,
  input wire logic [NUM_CH-1:0] tx_i,
  output logic [NUM_CH-1:0] rx_o
);
  // Lines idle high until told otherwise
  initial rx_o = '1;
  // Idle level: low for infrared, high for plain serial
  task set_idle(input int ch, input bit ir);
    rx_o[ch] <= !ir;
  endtask : set_idle
  // Catch one frame; start level equals the infrared flag
  task recv_byte(input int ch, input bit ir, output logic [7:0] b);
    int n;
    n = 0;
    while (tx_i[ch] !== ir && n < 4000) begin
      @(posedge core_clk_i);
      n++;
    end
    b = 'x;
    if (n < 4000) begin
      repeat (ir ? 1 : BIT_CYC / 2) @(posedge core_clk_i);
      for (int k = 0; k < 8; k++) begin
        repeat (BIT_CYC) @(posedge core_clk_i);
        b[k] = ir ? !tx_i[ch] : tx_i[ch];
      end
    end
  endtask : recv_byte
  // Send start, eight data bits LSB first, stop
  task send_byte(input int ch, input bit ir, input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      if (ir) begin
        rx_o[ch] <= !f[k];
        repeat (3) @(posedge core_clk_i);
        rx_o[ch] <= 1'b0;
        repeat (BIT_CYC - 3) @(posedge core_clk_i);
      end else begin
        rx_o[ch] <= f[k];
        repeat (BIT_CYC) @(posedge core_clk_i);
      end
    end
    rx_o[ch] <= !ir;
  endtask : send_byte
endmodule : serial_line_model

// file: test/uart_fifo_depth_irda_pinsel_tb.sv
// Self-checking bench for depth selection and pin modes
`timescale 1ns/100ps
`include "uart_cfg_map.svh"
module uart_fifo_depth_irda_pinsel_tb;
  import uart_cfg_pkg::*;
  logic clk, rst, psel, penable, pwrite, pin, pready, pslverr, er;
  logic [7:0] paddr;
  word_t pwdata, prdata, rd, dv;
  logic [1:0] rx_w, tx_w, deep_w;
  int mismatches, cmp_count, pin_m;
  int fbit_m[2], enh_m[2], lcr_m[2];
  logic [7:0] q[$];
  logic [7:0] bad[4] = '{8'h80, 8'h58, 8'h1c, 8'h03};
  uart_fifo_depth_irda_pinsel uart_fifo_depth_irda_pinsel_inst (
    .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .fifo_depth_select_pin_i(pin), .serial_rx_pin_i(rx_w),
    .serial_tx_pin_o(tx_w), .fifo_deep_o(deep_w));
  serial_line_model serial_line_model_inst (.core_clk_i(clk),
    .tx_i(tx_w), .rx_o(rx_w));
  // Clock, 100 ns period
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input word_t e, input word_t g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input word_t d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
    if (n >= 20) begin
      mismatches++;
      final_report();
    end
  endtask : apb
  // Register write plus model update
  task automatic wr(input int c, input logic [4:0] o, input word_t d);
    apb(1, 8'(c * 32) + o, d);
    if (o == `UCFG_OFF_LINE) lcr_m[c] = d[7];
    if (o == `UCFG_OFF_FIFO && lcr_m[c] != 0) fbit_m[c] = d[5];
    if (o == `UCFG_OFF_ENH) enh_m[c] = d[0];
  endtask : wr
  task automatic depth_chk();
    int d;
    for (int c = 0; c < 2; c++) begin
      d = pin_m | fbit_m[c] | enh_m[c];
      apb(0, 8'(c * 32) + `UCFG_OFF_STAT, 0);
      chk("pin bit", 32'(pin_m), 32'(rd[2]));
      chk("deep bit", 32'(d), 32'(rd[3]));
      chk("depth", d != 0 ? 32'h80 : 32'h10, 32'(rd[15:8]));
      chk("deep out", 32'(d), 32'(deep_w[c]));
    end
  endtask : depth_chk
  // Byte out through the far side, then a byte back in
  task automatic xfer(input int c, input bit ir);
    logic [7:0] s, g;
    s = 8'($urandom);
    q.push_back(s);
    fork
      wr(c, `UCFG_OFF_DATA, 32'(s));
      serial_line_model_inst.recv_byte(c, ir, g);
    join
    chk("tx byte", 32'(q.pop_front()), 32'(g));
    s = 8'($urandom);
    serial_line_model_inst.send_byte(c, ir, s);
    apb(0, 8'(c * 32) + `UCFG_OFF_DATA, 0);
    chk("rx byte", 32'(s), rd);
  endtask : xfer
  // Main sequence
  initial begin
    void'($urandom(32'ha61f));
    {rst, psel, penable, pwrite, pin, paddr, pwdata} = '0;
    rst = 1;
    {mismatches, cmp_count, pin_m} = '0;
    fbit_m = '{0, 0};
    enh_m = '{0, 0};
    lcr_m = '{0, 0};
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int v = 0; v < 3; v++) begin
      pin <= v[0];
      pin_m = v % 2;
      repeat (5) @(posedge clk);
      depth_chk();
    end
    $display("pin depth test done");
    wr(1, `UCFG_OFF_FIFO, 32'h20);
    wr(0, `UCFG_OFF_LINE, 32'h80);
    wr(0, `UCFG_OFF_FIFO, 32'h20);
    depth_chk();
    wr(1, `UCFG_OFF_ENH, 32'h1);
    depth_chk();
    $display("register depth test done");
    foreach (bad[i]) begin
      apb(0, bad[i], 0);
      chk("refused", 32'h1, 32'(er));
      chk("refused data", 32'h0, rd);
    end
    $display("unmapped test done");
    // Divisor reset value, read-back, then back to one tick per cycle
    for (int c = 0; c < 2; c++) begin
      apb(0, 8'(c * 32) + `UCFG_OFF_DIV, 0);
      chk("divisor reset", 32'(`UCFG_RST_DIV), rd);
      dv = {16'($urandom), 16'($urandom_range(9, 2))};
      wr(c, `UCFG_OFF_DIV, dv);
      apb(0, 8'(c * 32) + `UCFG_OFF_DIV, 0);
      chk("divisor", {16'h0, dv[15:0]}, rd);
      wr(c, `UCFG_OFF_DIV, 32'h1);
    end
    $display("divisor test done");
    wr(0, `UCFG_OFF_MODEM, 32'h40);
    xfer(0, 0);
    wr(1, `UCFG_OFF_MODEM, 32'h40);
    serial_line_model_inst.set_idle(1, 1);
    repeat (200) @(posedge clk);
    chk("ir idle", 32'h0, 32'(tx_w[1]));
    xfer(1, 1);
    wr(1, `UCFG_OFF_ENH, 32'h0);
    serial_line_model_inst.set_idle(1, 0);
    repeat (200) @(posedge clk);
    xfer(1, 0);
    depth_chk();
    wr(0, `UCFG_OFF_FIFO, 32'h0);
    depth_chk();
    $display("serial test done");
    final_report();
  end
endmodule : uart_fifo_depth_irda_pinsel_tb
